// [shared/clkdist_pkg.sv]
// Constants for the clock distribution and configuration block.
// Assumes a 32-bit Avalon-MM slave port with byte addresses and word-aligned registers.
package clkdist_pkg;
  // Register byte offsets
  localparam logic [5:0] ADDR_OUTPUT_CLOCK_CONTROL = 6'h00;
  localparam logic [5:0] ADDR_LOCALBUS_CLOCK_RATIO = 6'h04;
  localparam logic [5:0] ADDR_UNIT_CLOCK_CONTROL   = 6'h08;
  localparam logic [5:0] ADDR_MODE_STATUS          = 6'h0C;
  localparam logic [5:0] ADDR_CONFIG_WORD_LOW      = 6'h10;
  localparam logic [5:0] ADDR_SYSTEM_FREQ          = 6'h14;
  localparam logic [5:0] ADDR_PROCESSOR_FREQ       = 6'h18;
  localparam logic [5:0] ADDR_ENGINE_FREQ          = 6'h1C;
  localparam logic [5:0] ADDR_LOCALBUS_FREQ        = 6'h20;
  localparam logic [5:0] ADDR_SECURITY_FREQ        = 6'h24;

  // Number of per-slot clock outputs
  localparam int SLOT_COUNT = 3;

  // Low reset configuration word field positions
  localparam int LOCALBUS_RATIO_BIT_POS     = 31;
  localparam int MEMORY1_RATIO_BIT_POS   = 30;
  localparam int SYSTEM_PLL_MULTIPLIER_MSB     = 27;
  localparam int SYSTEM_PLL_MULTIPLIER_LSB     = 24;
  localparam int PROCESSOR_PLL_RATIO_MSB  = 22;
  localparam int PROCESSOR_PLL_RATIO_LSB  = 16;
  localparam int ENGINE_PLL_MULTIPLIER_MSB    = 12;
  localparam int ENGINE_PLL_MULTIPLIER_LSB    = 8;
  localparam int ENGINE_PLL_DIVIDER_POS    = 6;

  // Unit clock control fields
  localparam int SEC_RATIO_MSB = 1;
  localparam int SEC_RATIO_LSB = 0;
  localparam int PCI_ON_POS    = 4;

  // Local-bus divider select codes
  typedef enum logic [1:0] {LBDIV_RSVD, LBDIV_2, LBDIV_4, LBDIV_8} lbdiv_e;
  // Security unit clock ratio codes
  typedef enum logic [1:0] {SEC_OFF, SEC_FULL, SEC_HALF, SEC_THIRD} secratio_e;
  // Primary clock source
  typedef enum logic [1:0] {SRC_GENERAL, SRC_PCI_PIN, SRC_SYNC_IN} srcsel_e;

  // Reset values
  localparam logic [SLOT_COUNT-1:0] OCC_RESET   = 3'h0;
  localparam logic [1:0]            LBDIV_RESET = 2'h1;
  localparam logic [1:0]            SEC_RESET   = 2'h3;
  localparam logic                  PCI_RESET   = 1'b1;
endpackage

// [core/clock_distribution_config.sv]
// Clock source selection, PCI clock fan-out and derived-frequency bookkeeping.
// Assumes straps, configuration word and pin clocks are synchronous to I_CLK,
// and that sampled pin clocks toggle slower than I_CLK/2.
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ns
module clock_distribution_config
  import clkdist_pkg::*;
(
  // Clock and reset
  input  wire logic                  I_CLK,
  input  wire logic                  I_RST,
  // Straps and reset configuration
  input  wire logic                  I_HOST_ROLE_SELECT,
  input  wire logic                  I_SLOT_CLOCK_DRIVE_SELECT,
  input  wire logic                  I_INPUT_HALVE_STRAP,
  input  wire logic [31:0]           I_RESET_CONFIG_WORD_LOW,
  // Sampled clock pins and measured sync input frequency
  input  wire logic                  I_GENERAL_CLOCK_INPUT,
  input  wire logic [16:0]           I_SYNC_IN_FREQ_KHZ,
  // Avalon-MM slave
  input  wire logic [5:0]            I_AVS_ADDRESS,
  input  wire logic                  I_AVS_READ,
  input  wire logic                  I_AVS_WRITE,
  input  wire logic [31:0]           I_AVS_WRITEDATA,
  output logic      [31:0]           O_AVS_READDATA,
  output logic                       O_AVS_WAITREQUEST,
  // Clock pins and primary source code
  output logic                       O_SYNC_OUTPUT,
  output logic      [SLOT_COUNT-1:0] O_SLOT_CLOCK_OUTPUT,
  output logic      [1:0]            O_PRIMARY_SOURCE,
  // Derived frequencies in kHz, PCI complex clock enable and load flag
  output logic      [31:0]           O_SYSTEM_FREQ_KHZ,
  output logic      [31:0]           O_PROCESSOR_FREQ_KHZ,
  output logic      [31:0]           O_ENGINE_FREQ_KHZ,
  output logic      [31:0]           O_MEMORY1_INTERNAL_FREQ_KHZ,
  output logic      [31:0]           O_MEMORY1_BUS_FREQ_KHZ,
  output logic      [31:0]           O_MEMORY1_DATA_RATE_KHZ,
  output logic      [31:0]           O_LOCALBUS_INTERNAL_FREQ_KHZ,
  output logic      [31:0]           O_LOCALBUS_CLOCK_FREQ_KHZ,
  output logic      [31:0]           O_SECURITY_FREQ_KHZ,
  output logic                       O_PCI_COMPLEX_CLOCK_ON,
  output logic                       O_CONFIG_LOADED
);

  // Configuration capture and register state
  logic                  loaded_r;
  logic                  host_r;
  logic                  drive_r;
  logic                  halve_r;
  logic [31:0]           reset_config_word_low_r;
  logic [SLOT_COUNT-1:0] occ_r;
  logic [1:0]            lbdiv_r;
  logic [1:0]            sec_r;
  logic                  pci_on_r;
  logic                  ack_r;
  logic [31:0]           rdata_r;
  logic                  gen_prev_r;
  logic                  half_r;
  logic                  sync_r;
  logic [SLOT_COUNT-1:0] slot_r;
  logic [31:0]           sys_r;
  logic [31:0]           proc_r;
  logic [31:0]           eng_r;
  logic [31:0]           mem_r;
  logic [31:0]           lbi_r;
  logic [31:0]           lbx_r;
  logic [31:0]           secf_r;

  // Straps and configuration word are caught once, at the first edge after release
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      loaded_r <= 1'b0;
      host_r   <= 1'b0;
      drive_r  <= 1'b0;
      halve_r  <= 1'b0;
      reset_config_word_low_r   <= 32'h0;
    end else if (!loaded_r) begin
      loaded_r <= 1'b1;
      host_r   <= I_HOST_ROLE_SELECT;
      drive_r  <= I_SLOT_CLOCK_DRIVE_SELECT;
      halve_r  <= I_INPUT_HALVE_STRAP;
      reset_config_word_low_r   <= I_RESET_CONFIG_WORD_LOW;
    end
  end

  // Configuration word fields
  wire logic [3:0] system_pll_multiplier    = reset_config_word_low_r[SYSTEM_PLL_MULTIPLIER_MSB:SYSTEM_PLL_MULTIPLIER_LSB];
  wire logic [6:0] processor_pll_ratio = reset_config_word_low_r[PROCESSOR_PLL_RATIO_MSB:PROCESSOR_PLL_RATIO_LSB];
  wire logic [4:0] engine_pll_multiplier   = reset_config_word_low_r[ENGINE_PLL_MULTIPLIER_MSB:ENGINE_PLL_MULTIPLIER_LSB];
  wire logic       engine_pll_divider   = reset_config_word_low_r[ENGINE_PLL_DIVIDER_POS];
  wire logic       memory1_ratio_bit  = reset_config_word_low_r[MEMORY1_RATIO_BIT_POS];
  wire logic       localbus_ratio_bit    = reset_config_word_low_r[LOCALBUS_RATIO_BIT_POS];

  // Primary source: general input, PCI pin in agent mode, or sync input
  wire logic host_drive = host_r & drive_r;
  wire srcsel_e src     = !host_r ? SRC_PCI_PIN :
                          (drive_r ? SRC_GENERAL : SRC_SYNC_IN);

  // Frequency arithmetic; in agent mode the strap is grounded so the factor is one
  // All rates are 32-bit kHz words; legal settings stay far below the wrap point,
  // so no saturation logic was spent on out-of-range configuration words
  wire logic [31:0] sync_khz = {15'h0, I_SYNC_IN_FREQ_KHZ};
  wire logic [31:0] in_khz   = halve_r ? {sync_khz[30:0], 1'b0} : sync_khz;
  wire logic [31:0] prim_khz = host_drive ? in_khz : sync_khz;
  wire logic [31:0] sys_nxt  = in_khz * {28'h0, system_pll_multiplier};
  wire logic [31:0] pmul     = sys_r * {25'h0, processor_pll_ratio};
  wire logic [31:0] proc_nxt = {1'b0, pmul[31:1]};
  wire logic [31:0] emul     = prim_khz * {27'h0, engine_pll_multiplier};
  wire logic [31:0] eng_nxt  = engine_pll_divider ? {1'b0, emul[31:1]} : emul;
  wire logic [31:0] mem_nxt  = memory1_ratio_bit ? {sys_r[30:0], 1'b0} : sys_r;
  wire logic [31:0] lbi_nxt  = localbus_ratio_bit ? {sys_r[30:0], 1'b0} : sys_r;
  wire logic [31:0] lbx_nxt  = (lbdiv_r == LBDIV_8) ? {3'h0, lbi_r[31:3]} :
                               (lbdiv_r == LBDIV_4) ? {2'h0, lbi_r[31:2]} :
                                                      {1'b0, lbi_r[31:1]};
  wire logic [31:0] sec_nxt  = (sec_r == SEC_FULL)  ? sys_r :
                               (sec_r == SEC_HALF)  ? {1'b0, sys_r[31:1]} :
                               (sec_r == SEC_THIRD) ? sys_r / 32'd3 : 32'h0;

  // Frequency pipeline; holds zero until configuration has loaded
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      sys_r  <= 32'h0;
      proc_r <= 32'h0;
      eng_r  <= 32'h0;
      mem_r  <= 32'h0;
      lbi_r  <= 32'h0;
      lbx_r  <= 32'h0;
      secf_r <= 32'h0;
    end else if (loaded_r) begin
      sys_r  <= sys_nxt;
      proc_r <= proc_nxt;
      eng_r  <= eng_nxt;
      mem_r  <= mem_nxt;
      lbi_r  <= lbi_nxt;
      lbx_r  <= lbx_nxt;
      secf_r <= sec_nxt;
    end
  end

  // General input halver; edge detection is safe since pins are synchronous
  wire logic gen_rise = I_GENERAL_CLOCK_INPUT & ~gen_prev_r;
  wire logic sync_nxt = host_drive & (halve_r ? half_r : I_GENERAL_CLOCK_INPUT);
  wire logic [SLOT_COUNT-1:0] slot_nxt = {SLOT_COUNT{host_drive & half_r}} & occ_r;

  // Pin clock outputs stay low in reset and before the straps are known
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      gen_prev_r <= 1'b0;
      half_r     <= 1'b0;
      sync_r     <= 1'b0;
      slot_r     <= '0;
    end else if (loaded_r) begin
      gen_prev_r <= I_GENERAL_CLOCK_INPUT;
      half_r     <= (host_drive & gen_rise) ? ~half_r : half_r;
      sync_r     <= sync_nxt;
      slot_r     <= slot_nxt;
    end
  end

  // Bus decode; one wait cycle per access keeps read data registered
  // The mux is captured in the wait cycle, so read data already stands
  // at the edge where waitrequest is seen low
  wire logic req      = I_AVS_READ | I_AVS_WRITE;
  wire logic wr_take  = I_AVS_WRITE & ack_r;
  wire logic sel_occ  = (I_AVS_ADDRESS == ADDR_OUTPUT_CLOCK_CONTROL);
  wire logic sel_lbr  = (I_AVS_ADDRESS == ADDR_LOCALBUS_CLOCK_RATIO);
  wire logic sel_unit = (I_AVS_ADDRESS == ADDR_UNIT_CLOCK_CONTROL);
  wire logic [31:0] mode_word = {26'h0, loaded_r, src, halve_r, drive_r, host_r};
  wire logic [31:0] unit_word = {27'h0, pci_on_r, 2'h0, sec_r};
  wire logic [31:0] rd_mux =
    sel_occ  ? {{(32-SLOT_COUNT){1'b0}}, occ_r} :
    sel_lbr  ? {30'h0, lbdiv_r} :
    sel_unit ? unit_word :
    (I_AVS_ADDRESS == ADDR_MODE_STATUS)     ? mode_word :
    (I_AVS_ADDRESS == ADDR_CONFIG_WORD_LOW) ? reset_config_word_low_r :
    (I_AVS_ADDRESS == ADDR_SYSTEM_FREQ)     ? sys_r :
    (I_AVS_ADDRESS == ADDR_PROCESSOR_FREQ)  ? proc_r :
    (I_AVS_ADDRESS == ADDR_ENGINE_FREQ)     ? eng_r :
    (I_AVS_ADDRESS == ADDR_LOCALBUS_FREQ)   ? lbx_r :
    (I_AVS_ADDRESS == ADDR_SECURITY_FREQ)   ? secf_r : 32'h0;

  // Handshake and read data capture
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      ack_r   <= req & ~ack_r;
      rdata_r <= (I_AVS_READ & ~ack_r) ? rd_mux : rdata_r;
    end
  end

  // Software-written controls; a reserved divider code falls back to divide by 2
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      occ_r    <= OCC_RESET;
      lbdiv_r  <= LBDIV_RESET;
      sec_r    <= SEC_RESET;
      pci_on_r <= PCI_RESET;
    end else if (wr_take) begin
      if (sel_occ) begin
        occ_r <= I_AVS_WRITEDATA[SLOT_COUNT-1:0];
      end
      if (sel_lbr) begin
        lbdiv_r <= (I_AVS_WRITEDATA[1:0] == LBDIV_RSVD) ? LBDIV_2 : I_AVS_WRITEDATA[1:0];
      end
      if (sel_unit) begin
        sec_r    <= I_AVS_WRITEDATA[SEC_RATIO_MSB:SEC_RATIO_LSB];
        pci_on_r <= I_AVS_WRITEDATA[PCI_ON_POS];
      end
    end
  end

  // Output drive
  // Memory bus pins run at half the internal rate; data moves on both edges
  assign O_AVS_WAITREQUEST            = req & ~ack_r;
  assign O_AVS_READDATA               = rdata_r;
  assign O_SYNC_OUTPUT                = sync_r;
  assign O_SLOT_CLOCK_OUTPUT          = slot_r;
  assign O_PRIMARY_SOURCE             = src;
  assign O_SYSTEM_FREQ_KHZ            = sys_r;
  assign O_PROCESSOR_FREQ_KHZ         = proc_r;
  assign O_ENGINE_FREQ_KHZ            = eng_r;
  assign O_MEMORY1_INTERNAL_FREQ_KHZ  = mem_r;
  assign O_MEMORY1_BUS_FREQ_KHZ       = {1'b0, mem_r[31:1]};
  assign O_MEMORY1_DATA_RATE_KHZ      = mem_r;
  assign O_LOCALBUS_INTERNAL_FREQ_KHZ = lbi_r;
  assign O_LOCALBUS_CLOCK_FREQ_KHZ    = lbx_r;
  assign O_SECURITY_FREQ_KHZ          = secf_r;
  assign O_PCI_COMPLEX_CLOCK_ON       = pci_on_r & loaded_r;
  assign O_CONFIG_LOADED              = loaded_r;

  // Checks
  chk_slot_gated: assert property (@(posedge I_CLK) disable iff (I_RST)
    (slot_r & ~$past(occ_r)) == '0)
    else $error("slot clock driven while its enable is clear");
  chk_sync_halved: assert property (@(posedge I_CLK) disable iff (I_RST)
    $past(loaded_r) && $past(halve_r) |-> sync_r == ($past(host_drive) & $past(half_r)))
    else $error("sync output does not follow halved input");
  chk_source_agent: assert property (@(posedge I_CLK) disable iff (I_RST)
    loaded_r && !host_r |-> src == SRC_PCI_PIN)
    else $error("agent mode not on PCI pin");
  chk_source_host: assert property (@(posedge I_CLK) disable iff (I_RST)
    loaded_r && host_r |-> src == (drive_r ? SRC_GENERAL : SRC_SYNC_IN))
    else $error("host mode source wrong");
  chk_system_freq: assert property (@(posedge I_CLK) disable iff (I_RST)
    loaded_r && $stable(I_SYNC_IN_FREQ_KHZ) ##1 loaded_r |->
      sys_r == $past(in_khz) * {28'h0, system_pll_multiplier})
    else $error("system frequency mismatch");
  chk_memory_rate: assert property (@(posedge I_CLK) disable iff (I_RST)
    O_MEMORY1_DATA_RATE_KHZ[31:1] == O_MEMORY1_BUS_FREQ_KHZ[30:0])
    else $error("memory data rate not twice bus clock");
  chk_lb_divider: assert property (@(posedge I_CLK) disable iff (I_RST)
    loaded_r && lbdiv_r == LBDIV_8 ##1 lbdiv_r == LBDIV_8 |-> lbx_r == ($past(lbi_r) >> 3))
    else $error("local-bus divide by 8 wrong");
  chk_idle_reset: assert property (@(posedge I_CLK) disable iff (I_RST)
    !loaded_r |-> !sync_r && slot_r == '0 && sys_r == 32'h0)
    else $error("outputs active before configuration load");
  chk_wait_one: assert property (@(posedge I_CLK) disable iff (I_RST)
    $rose(req) |-> O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST)
    else $error("access not answered after one wait cycle");
  chk_security_third: assert property (@(posedge I_CLK) disable iff (I_RST)
    $rose(loaded_r) |-> sec_r == SEC_THIRD && pci_on_r)
    else $error("unit clock defaults wrong after reset");

  // Pin clock checks, then the host sync source; each pin clock is one edge behind the state that forms it
  chk_sync_direct: assert property (@(posedge I_CLK) disable iff (I_RST)
    $past(loaded_r) && !$past(halve_r) |-> sync_r == ($past(host_drive) & $past(I_GENERAL_CLOCK_INPUT)))
    else $error("sync output does not follow general input");
  chk_halver_toggle: assert property (@(posedge I_CLK) disable iff (I_RST)
    $past(loaded_r) && $past(host_drive & gen_rise) |-> half_r != $past(half_r))
    else $error("halver missed an input rise");
  chk_slot_follow: assert property (@(posedge I_CLK) disable iff (I_RST)
    $past(loaded_r) |-> slot_r == ({SLOT_COUNT{$past(host_drive & half_r)}} & $past(occ_r)))
    else $error("slot clock not halved input");
  chk_quiet_nodrive: assert property (@(posedge I_CLK) disable iff (I_RST)
    $past(loaded_r) && !$past(host_drive) |-> !sync_r && slot_r == '0)
    else $error("pin clocks driven without clock drive");
  chk_source_sync: assert property (@(posedge I_CLK) disable iff (I_RST)
    loaded_r && host_r && !drive_r |-> src == SRC_SYNC_IN)
    else $error("host without drive not on sync input");

  // Derived rate checks against the previous edge
  chk_processor_freq: assert property (@(posedge I_CLK) disable iff (I_RST)
    $past(loaded_r) |-> proc_r == (($past(sys_r) * {25'h0, processor_pll_ratio}) >> 1))
    else $error("processor frequency mismatch");
  chk_engine_freq: assert property (@(posedge I_CLK) disable iff (I_RST)
    $past(loaded_r) |-> eng_r == (($past(prim_khz) * {27'h0, engine_pll_multiplier}) >> engine_pll_divider))
    else $error("engine frequency mismatch");
  chk_memory_ratio: assert property (@(posedge I_CLK) disable iff (I_RST)
    $past(loaded_r) |-> mem_r == ($past(sys_r) << memory1_ratio_bit))
    else $error("memory internal frequency mismatch");
  chk_lb_internal: assert property (@(posedge I_CLK) disable iff (I_RST)
    $past(loaded_r) |-> lbi_r == ($past(sys_r) << localbus_ratio_bit))
    else $error("local-bus internal frequency mismatch");

  // Software-visible controls
  chk_lb_halve: assert property (@(posedge I_CLK) disable iff (I_RST)
    $past(loaded_r) && $past(lbdiv_r) == LBDIV_2 |-> lbx_r == ($past(lbi_r) >> 1))
    else $error("local-bus divide by 2 wrong");
  chk_lb_code: assert property (@(posedge I_CLK) disable iff (I_RST)
    lbdiv_r != LBDIV_RSVD)
    else $error("reserved divider code stored");
  chk_lb_write: assert property (@(posedge I_CLK) disable iff (I_RST)
    wr_take && sel_lbr && I_AVS_WRITEDATA[1:0] != 2'h0 |=> lbdiv_r == $past(I_AVS_WRITEDATA[1:0]))
    else $error("divider write not stored");
  chk_security_half: assert property (@(posedge I_CLK) disable iff (I_RST)
    $past(loaded_r) && $past(sec_r) == SEC_HALF |-> secf_r == ($past(sys_r) >> 1))
    else $error("security half rate wrong");
  chk_security_off: assert property (@(posedge I_CLK) disable iff (I_RST)
    $past(loaded_r) && $past(sec_r) == SEC_OFF |-> secf_r == 32'h0)
    else $error("security clock not off");
  chk_pci_gate: assert property (@(posedge I_CLK) disable iff (I_RST)
    O_PCI_COMPLEX_CLOCK_ON |-> pci_on_r && loaded_r)
    else $error("PCI complex clock on while disabled");
  chk_config_held: assert property (@(posedge I_CLK) disable iff (I_RST)
    $past(loaded_r) |-> $stable(reset_config_word_low_r) && $stable(host_r))
    else $error("configuration changed after load");

  cov_host_drive: cover property (@(posedge I_CLK) disable iff (I_RST)
    loaded_r && host_drive && $rose(sync_r));
  cov_agent: cover property (@(posedge I_CLK) disable iff (I_RST) loaded_r && !host_r);
  cov_write_occ: cover property (@(posedge I_CLK) disable iff (I_RST) wr_take && sel_occ);
  cov_sec_full: cover property (@(posedge I_CLK) disable iff (I_RST) sec_r == SEC_FULL);
  cov_halved_sync: cover property (@(posedge I_CLK) disable iff (I_RST)
    loaded_r && halve_r && host_drive && $rose(sync_r));

endmodule

// [verif/board_clock_model.sv]
// Board-side model: oscillator on the general clock pin and the sync loop.
// Assumes straps are constant while the device leaves reset.
`timescale 1ns/1ns
module board_clock_model #(
  parameter int GEN_KHZ = 33333,
  parameter int PCI_KHZ = 33333,
  parameter int HALF    = 3
) (
  // Board straps seen by the board logic
  input  wire logic        i_clk,
  input  wire logic        i_host,
  input  wire logic        i_drive,
  input  wire logic        i_halve,
  // Pins toward the device
  output logic             o_general_clock,
  output logic [16:0]      o_sync_freq_khz
);
  int cnt;
  initial begin
    o_general_clock = 1'b0;
    cnt = 0;
  end
  // Slow oscillator; an agent board grounds the pin instead
  always @(posedge i_clk) begin
    if (!i_host) begin
      o_general_clock <= 1'b0;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      o_general_clock <= ~o_general_clock;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // Matched-delay loop: sync input carries the driven sync rate, else the PCI clock
  assign o_sync_freq_khz = 17'((i_host && i_drive) ? (i_halve ? GEN_KHZ / 2 : GEN_KHZ)
                                                   : PCI_KHZ);
endmodule

// [verif/clock_distribution_config_tb.sv]
// Self-checking bench for the clock distribution block over its Avalon-MM port.
// Assumes the board model drives the general clock pin and sync frequency.
`timescale 1ns/1ns
module clock_distribution_config_tb;
  import clkdist_pkg::*;
  localparam int GEN_KHZ = 33333;
  localparam int PCI_KHZ = 33333;
  logic I_CLK, I_RST, I_HOST_ROLE_SELECT, I_SLOT_CLOCK_DRIVE_SELECT, I_INPUT_HALVE_STRAP;
  logic [31:0] I_RESET_CONFIG_WORD_LOW, I_AVS_WRITEDATA, O_AVS_READDATA, rd;
  logic I_GENERAL_CLOCK_INPUT, I_AVS_READ, I_AVS_WRITE, O_AVS_WAITREQUEST, O_SYNC_OUTPUT;
  logic [16:0] I_SYNC_IN_FREQ_KHZ;
  logic [5:0] I_AVS_ADDRESS;
  logic [SLOT_COUNT-1:0] O_SLOT_CLOCK_OUTPUT;
  logic [1:0] O_PRIMARY_SOURCE;
  logic [31:0] O_SYSTEM_FREQ_KHZ, O_PROCESSOR_FREQ_KHZ, O_ENGINE_FREQ_KHZ, O_SECURITY_FREQ_KHZ;
  logic [31:0] O_MEMORY1_INTERNAL_FREQ_KHZ, O_MEMORY1_BUS_FREQ_KHZ, O_MEMORY1_DATA_RATE_KHZ;
  logic [31:0] O_LOCALBUS_INTERNAL_FREQ_KHZ, O_LOCALBUS_CLOCK_FREQ_KHZ;
  logic O_PCI_COMPLEX_CLOCK_ON, O_CONFIG_LOADED;
  int error_cnt, compares, gen_rise, sync_tgl, follow_bad, sys;
  int slot_tgl [SLOT_COUNT];

  clock_distribution_config u_clock_distribution_config (.*);
  board_clock_model #(.GEN_KHZ(GEN_KHZ), .PCI_KHZ(PCI_KHZ)) u_board_clock_model (
    .i_clk(I_CLK), .i_host(I_HOST_ROLE_SELECT), .i_drive(I_SLOT_CLOCK_DRIVE_SELECT),
    .i_halve(I_INPUT_HALVE_STRAP), .o_general_clock(I_GENERAL_CLOCK_INPUT),
    .o_sync_freq_khz(I_SYNC_IN_FREQ_KHZ));

  // 100 MHz clock
  initial begin
    I_CLK = 1'b0;
    forever #5 I_CLK = ~I_CLK;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("unexpected %s expected %0h seen %0h", nm, exp, got);
      error_cnt++;
    end
  endtask

  // One bus transfer; the request holds until waitrequest is sampled low
  task automatic av_xfer(input logic wr, input logic [5:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    I_AVS_ADDRESS <= a;
    I_AVS_WRITE <= wr;
    I_AVS_READ <= !wr;
    I_AVS_WRITEDATA <= wd;
    do begin
      @(posedge I_CLK);
      n++;
    end while (O_AVS_WAITREQUEST !== 1'b0 && n < 20);
    rd = O_AVS_READDATA;
    I_AVS_WRITE <= 1'b0;
    I_AVS_READ <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      end_of_test();
    end
    @(posedge I_CLK);
  endtask

  task automatic rd_chk(input string nm, input logic [5:0] a, input logic [31:0] exp);
    av_xfer(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask

  function automatic logic [31:0] mk_cfg(input logic lb, input logic dd, input logic [3:0] system_pll_multiplier,
                                         input logic [6:0] core, input logic [4:0] engine_pll_multiplier,
                                         input logic engine_pll_divider);
    logic [31:0] w;
    w = 32'h0;
    w[LOCALBUS_RATIO_BIT_POS] = lb;
    w[MEMORY1_RATIO_BIT_POS] = dd;
    w[SYSTEM_PLL_MULTIPLIER_MSB:SYSTEM_PLL_MULTIPLIER_LSB] = system_pll_multiplier;
    w[PROCESSOR_PLL_RATIO_MSB:PROCESSOR_PLL_RATIO_LSB] = core;
    w[ENGINE_PLL_MULTIPLIER_MSB:ENGINE_PLL_MULTIPLIER_LSB] = engine_pll_multiplier;
    w[ENGINE_PLL_DIVIDER_POS] = engine_pll_divider;
    return w;
  endfunction

  // Straps are only captured at the first edge after release
  task automatic do_reset(input logic h, input logic d, input logic s, input logic [31:0] cfg);
    I_RST <= 1'b1;
    I_HOST_ROLE_SELECT <= h;
    I_SLOT_CLOCK_DRIVE_SELECT <= d;
    I_INPUT_HALVE_STRAP <= s;
    I_RESET_CONFIG_WORD_LOW <= cfg;
    repeat (8) @(posedge I_CLK);
    chk("loaded in reset", 32'h0, O_CONFIG_LOADED);
    chk("system in reset", 32'h0, O_SYSTEM_FREQ_KHZ);
    chk("slots in reset", 32'h0, O_SLOT_CLOCK_OUTPUT);
    I_RST <= 1'b0;
    repeat (6) @(posedge I_CLK);
    chk("loaded", 32'h1, O_CONFIG_LOADED);
    rd_chk("config word", ADDR_CONFIG_WORD_LOW, cfg);
  endtask

  task automatic chk_freqs(input int sy, input int pr, input int en, input int mi, input int li,
                           input int lx, input int se);
    chk("system", sy, O_SYSTEM_FREQ_KHZ);
    chk("processor", pr, O_PROCESSOR_FREQ_KHZ);
    chk("engine", en, O_ENGINE_FREQ_KHZ);
    chk("memory internal", mi, O_MEMORY1_INTERNAL_FREQ_KHZ);
    chk("memory bus", mi / 2, O_MEMORY1_BUS_FREQ_KHZ);
    chk("memory rate", mi, O_MEMORY1_DATA_RATE_KHZ);
    chk("lb internal", li, O_LOCALBUS_INTERNAL_FREQ_KHZ);
    chk("lb external", lx, O_LOCALBUS_CLOCK_FREQ_KHZ);
    chk("security", se, O_SECURITY_FREQ_KHZ);
  endtask

  // Watches the pins between falling edges, where registered outputs are settled
  task automatic pin_watch(input int n);
    logic pg, ps;
    logic [SLOT_COUNT-1:0] pslot;
    gen_rise = 0;
    sync_tgl = 0;
    follow_bad = 0;
    foreach (slot_tgl[i]) slot_tgl[i] = 0;
    @(negedge I_CLK);
    {pg, ps, pslot} = {I_GENERAL_CLOCK_INPUT, O_SYNC_OUTPUT, O_SLOT_CLOCK_OUTPUT};
    repeat (n) begin
      @(negedge I_CLK);
      if (O_SYNC_OUTPUT !== pg) follow_bad++;
      if (I_GENERAL_CLOCK_INPUT && !pg) gen_rise++;
      if (O_SYNC_OUTPUT !== ps) sync_tgl++;
      for (int i = 0; i < SLOT_COUNT; i++) if (O_SLOT_CLOCK_OUTPUT[i] !== pslot[i]) slot_tgl[i]++;
      {pg, ps, pslot} = {I_GENERAL_CLOCK_INPUT, O_SYNC_OUTPUT, O_SLOT_CLOCK_OUTPUT};
    end
    @(posedge I_CLK);
  endtask

  initial begin
    {I_RST, I_HOST_ROLE_SELECT, I_SLOT_CLOCK_DRIVE_SELECT, I_INPUT_HALVE_STRAP} = 4'h8;
    {I_AVS_READ, I_AVS_WRITE, I_AVS_ADDRESS, I_AVS_WRITEDATA} = '0;
    I_RESET_CONFIG_WORD_LOW = 32'h0;
    error_cnt = 0;
    compares = 0;
    // Host driving clocks, undivided sync output, 33 MHz input
    do_reset(1'b1, 1'b1, 1'b0, mk_cfg(1'b0, 1'b0, 4'h4, 7'h04, 5'h0C, 1'b0));
    sys = GEN_KHZ * 4;
    chk_freqs(sys, sys * 2, GEN_KHZ * 12, sys, sys, sys / 2, sys / 3);
    chk("source", SRC_GENERAL, O_PRIMARY_SOURCE);
    chk("system range", 32'h1, sys >= 133000 && sys <= 266667);
    chk("pci on", 32'h1, O_PCI_COMPLEX_CLOCK_ON);
    rd_chk("occ reset", ADDR_OUTPUT_CLOCK_CONTROL, 32'h0);
    rd_chk("lcr reset", ADDR_LOCALBUS_CLOCK_RATIO, 32'h1);
    rd_chk("unit reset", ADDR_UNIT_CLOCK_CONTROL, 32'h13);
    rd_chk("status", ADDR_MODE_STATUS, 32'h23);
    rd_chk("system reg", ADDR_SYSTEM_FREQ, sys);
    av_xfer(1'b1, 6'h28, 32'hFFFFFFFF);
    rd_chk("unmapped", 6'h28, 32'h0);
    for (int c = 0; c < 4; c++) begin
      av_xfer(1'b1, ADDR_UNIT_CLOCK_CONTROL, 32'h10 | c);
      repeat (3) @(posedge I_CLK);
      chk("security ratio", (c == 0) ? 0 : sys / c, O_SECURITY_FREQ_KHZ);
    end
    av_xfer(1'b1, ADDR_UNIT_CLOCK_CONTROL, 32'h3);
    repeat (3) @(posedge I_CLK);
    chk("pci off", 32'h0, O_PCI_COMPLEX_CLOCK_ON);
    for (int c = 1; c < 4; c++) begin
      av_xfer(1'b1, ADDR_LOCALBUS_CLOCK_RATIO, c);
      repeat (4) @(posedge I_CLK);
      chk("lb divider", sys >> c, O_LOCALBUS_CLOCK_FREQ_KHZ);
    end
    av_xfer(1'b1, ADDR_LOCALBUS_CLOCK_RATIO, 32'h0);
    rd_chk("lb code zero", ADDR_LOCALBUS_CLOCK_RATIO, 32'h1);
    av_xfer(1'b1, ADDR_OUTPUT_CLOCK_CONTROL, 32'h5);
    pin_watch(72);
    chk("sync follows", 32'h0, follow_bad);
    chk("slot0 halves", 32'h1, slot_tgl[0] >= gen_rise - 1 && slot_tgl[0] <= gen_rise + 1);
    chk("slot1 off", 32'h0, slot_tgl[1]);
    chk("slot2 on", 32'h1, slot_tgl[2] > 0);
    // Host driving clocks with halved sync output and doubled ratios
    do_reset(1'b1, 1'b1, 1'b1, mk_cfg(1'b1, 1'b1, 4'h4, 7'h05, 5'h0C, 1'b1));
    sys = (GEN_KHZ / 2) * 2 * 4;
    chk_freqs(sys, sys * 5 / 2, (GEN_KHZ / 2) * 2 * 12 / 2, sys * 2, sys * 2, sys, sys / 3);
    pin_watch(72);
    chk("sync halves", 32'h1, sync_tgl >= gen_rise - 1 && sync_tgl <= gen_rise + 1);
    chk("slots idle", 32'h0, slot_tgl[0] + slot_tgl[1] + slot_tgl[2]);
    // Host with board-side distribution
    do_reset(1'b1, 1'b0, 1'b0, mk_cfg(1'b0, 1'b0, 4'h5, 7'h04, 5'h09, 1'b0));
    chk("source sync", SRC_SYNC_IN, O_PRIMARY_SOURCE);
    chk("engine sync", PCI_KHZ * 9, O_ENGINE_FREQ_KHZ);
    rd_chk("status sync", ADDR_MODE_STATUS, 32'h31);
    av_xfer(1'b1, ADDR_OUTPUT_CLOCK_CONTROL, 32'h7);
    pin_watch(36);
    chk("sync quiet", 32'h0, sync_tgl + O_SYNC_OUTPUT);
    chk("slots quiet", 32'h0, slot_tgl[0] + slot_tgl[1] + slot_tgl[2]);
    // Agent mode on the PCI clock pin
    do_reset(1'b0, 1'b0, 1'b0, mk_cfg(1'b0, 1'b0, 4'h4, 7'h04, 5'h0C, 1'b0));
    chk("source pin", SRC_PCI_PIN, O_PRIMARY_SOURCE);
    chk("agent system", PCI_KHZ * 4, O_SYSTEM_FREQ_KHZ);
    rd_chk("status agent", ADDR_MODE_STATUS, 32'h28);
    end_of_test();
  end
endmodule
